// ### breaker_failure_supervisor.sv
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - backup asserts after drive outlasts operate delay
// - backup holds while drive active, then releases
// - all sources on supervised output ored
// - supervised output selectable among fitted trips
// - delay 0.1 to 10 s, 0.1 s steps
// - two identical staged units: re-trip, upstream
// - disabled unit gives no start or trip
// - start and timer run while condition active
// - block freezes timer count without clearing
// - block forces start and trip low
// - four edge events, each individually enabled
// - four condition selectors, any combination
// - conditions one to three: six stages
// - stage trip starts evaluation without delay
// - condition four: three signals, self reset
// - breaker status resets all; stage drop resets
// - zero phase / earth current resets one, two
// - monitoring enable per condition, set after reset
// - zero current has own separate thresholds
// - source counts only when stage enabled, started
module breaker_failure_supervisor #(
  parameter int N_SRC = 16,
  parameter int N_TRIP = 4,
  parameter int N_STG = 32,
  parameter int N_DI = 8,
  parameter int N_OC = 8,
  parameter int N_CB = 8,
  parameter int CUR_W = 16,
  parameter int TICK_CYCLES = bf_pkg::TICK_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [N_SRC-1:0] sup_src,
  input wire logic [4*N_SRC-1:0] sup_route,
  input wire logic [1:0] sup_out_sel,
  input wire logic [6:0] sup_delay,
  output logic sup_backup,
  input wire logic [N_STG-1:0] stage_start,
  input wire logic [N_STG-1:0] stage_enable,
  input wire logic [N_DI-1:0] din_pin,
  input wire logic [N_OC-1:0] contact_state,
  input wire logic [N_CB-1:0] cb_status_pin,
  input wire logic [CUR_W-1:0] ph_i_a,
  input wire logic [CUR_W-1:0] ph_i_b,
  input wire logic [CUR_W-1:0] ph_i_c,
  input wire logic [CUR_W-1:0] ef_i,
  input wire logic [CUR_W-1:0] ph_zc_thr,
  input wire logic [CUR_W-1:0] ef_zc_thr,
  input wire logic first_unit_enable,
  input wire logic second_unit_enable,
  input wire logic [1:0] unit_block,
  input wire logic [7:0] unit_mon_en,
  input wire logic [2*18*$clog2(N_STG)-1:0] unit_slot_idx,
  input wire logic [35:0] unit_slot_vld,
  input wire logic [6*$clog2(N_DI+N_OC)-1:0] unit_slot4_idx,
  input wire logic [5:0] unit_slot4_vld,
  input wire logic [2*$clog2(N_CB)-1:0] unit_cb_sel,
  input wire logic [7:0] unit_rst_cb_en,
  input wire logic [5:0] unit_rst_stg_en,
  input wire logic [1:0] unit_rst_zc_ph,
  input wire logic [1:0] unit_rst_zc_ef,
  input wire logic [31:0] unit_delay,
  input wire logic [7:0] unit_ev_en,
  output logic retrip_start,
  output logic retrip_trip,
  output logic upstream_start,
  output logic upstream_trip,
  output logic [7:0] unit_event
);
  localparam int SW = $clog2(N_STG);
  localparam int N_MON = N_DI + N_OC;
  localparam int MW = $clog2(N_MON);
  localparam int CBW = $clog2(N_CB);
  localparam int TW = $clog2(TICK_CYCLES) + 1;

  // ------------------------------------------------------------
  // parameter checks
  // ------------------------------------------------------------
  if (N_TRIP < 1 || N_TRIP > bf_pkg::N_TRIP_MAX) begin : g_bad_trip
    $error("n_trip must be 1 to 4");
  end
  if (N_STG < 2 || N_STG != 2**SW) begin : g_bad_stg
    $error("n_stg must be a power of two");
  end
  if (N_MON < 2 || N_MON != 2**MW) begin : g_bad_mon
    $error("n_di plus n_oc must be a power of two");
  end
  if (N_CB < 2 || N_CB != 2**CBW) begin : g_bad_cb
    $error("n_cb must be a power of two");
  end
  if (TICK_CYCLES < 2) begin : g_bad_tick
    $error("tick_cycles must be at least 2");
  end

  logic [TW-1:0] tick_cnt_q;
  logic tick_q;
  logic [N_TRIP-1:0] drv;
  logic sup_drive;
  logic [N_DI-1:0] din_m_q, din_s_q;
  logic [N_CB-1:0] cb_m_q, cb_s_q;
  logic ph_zero_q, ef_zero_q;
  logic [N_STG-1:0] stg_act;
  logic [N_MON-1:0] mon_sig;
  logic cb_open0, cb_open1;

  // ------------------------------------------------------------
  // millisecond timebase
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (tick_cnt_q == TW'(TICK_CYCLES - 1)) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // single-stage supervision of one trip output
  // ------------------------------------------------------------
  always_comb begin
    for (int k = 0; k < N_TRIP; k++) begin
      drv[k] = |(sup_src & sup_route[k*N_SRC +: N_SRC]);
    end
  end

  // an unfitted output never drives, so its supervisor stays idle
  assign sup_drive = (int'(sup_out_sel) < N_TRIP) ? drv[sup_out_sel] : 1'b0;

  bf_sup u_sup (
    .clk(clk),
    .nrst(nrst),
    .tick(tick_q),
    .drive(sup_drive),
    .delay_set(sup_delay),
    .backup_q(sup_backup)
  );

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      din_m_q <= '0;
      din_s_q <= '0;
    end else begin
      din_m_q <= din_pin;
      din_s_q <= din_m_q;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cb_m_q <= '0;
      cb_s_q <= '0;
    end else begin
      cb_m_q <= cb_status_pin;
      cb_s_q <= cb_m_q;
    end
  end

  // ------------------------------------------------------------
  // zero-current detection and shared condition inputs
  // ------------------------------------------------------------
  // independent of every stage; only measured current against threshold
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ph_zero_q <= 1'b0;
      ef_zero_q <= 1'b0;
    end else begin
      ph_zero_q <= (ph_i_a < ph_zc_thr) && (ph_i_b < ph_zc_thr) && (ph_i_c < ph_zc_thr);
      ef_zero_q <= ef_i < ef_zc_thr;
    end
  end

  assign stg_act = stage_start & stage_enable;
  assign mon_sig = {contact_state, din_s_q};
  assign cb_open0 = cb_s_q[unit_cb_sel[0 +: CBW]];
  assign cb_open1 = cb_s_q[unit_cb_sel[CBW +: CBW]];

  // ------------------------------------------------------------
  // staged units: re-trip and upstream backup
  // ------------------------------------------------------------
  bf_unit #(.N_STG(N_STG), .N_MON(N_MON)) u_unit0 (
    .clk(clk),
    .nrst(nrst),
    .tick(tick_q),
    .enable(first_unit_enable),
    .block(unit_block[0]),
    .stg_act(stg_act),
    .mon_sig(mon_sig),
    .cb_open(cb_open0),
    .ph_zero(ph_zero_q),
    .ef_zero(ef_zero_q),
    .mon_en(unit_mon_en[3:0]),
    .slot_idx(unit_slot_idx[0 +: 18*SW]),
    .slot_vld(unit_slot_vld[17:0]),
    .slot4_idx(unit_slot4_idx[0 +: 3*MW]),
    .slot4_vld(unit_slot4_vld[2:0]),
    .rst_cb_en(unit_rst_cb_en[3:0]),
    .rst_stg_en(unit_rst_stg_en[2:0]),
    .rst_zc_ph(unit_rst_zc_ph[0]),
    .rst_zc_ef(unit_rst_zc_ef[0]),
    .delay(unit_delay[15:0]),
    .ev_en(unit_ev_en[3:0]),
    .start_q(retrip_start),
    .trip_q(retrip_trip),
    .ev_q(unit_event[3:0])
  );

  bf_unit #(.N_STG(N_STG), .N_MON(N_MON)) u_unit1 (
    .clk(clk),
    .nrst(nrst),
    .tick(tick_q),
    .enable(second_unit_enable),
    .block(unit_block[1]),
    .stg_act(stg_act),
    .mon_sig(mon_sig),
    .cb_open(cb_open1),
    .ph_zero(ph_zero_q),
    .ef_zero(ef_zero_q),
    .mon_en(unit_mon_en[7:4]),
    .slot_idx(unit_slot_idx[18*SW +: 18*SW]),
    .slot_vld(unit_slot_vld[35:18]),
    .slot4_idx(unit_slot4_idx[3*MW +: 3*MW]),
    .slot4_vld(unit_slot4_vld[5:3]),
    .rst_cb_en(unit_rst_cb_en[7:4]),
    .rst_stg_en(unit_rst_stg_en[5:3]),
    .rst_zc_ph(unit_rst_zc_ph[1]),
    .rst_zc_ef(unit_rst_zc_ef[1]),
    .delay(unit_delay[31:16]),
    .ev_en(unit_ev_en[7:4]),
    .start_q(upstream_start),
    .trip_q(upstream_trip),
    .ev_q(unit_event[7:4])
  );

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_backup_drive: assert property (@(posedge clk) disable iff (!nrst)
    sup_backup |-> $past(sup_drive))
    else $error("backup without drive");

  a_backup_release: assert property (@(posedge clk) disable iff (!nrst)
    !sup_drive |=> !sup_backup)
    else $error("backup held after drive reset");

  a_backup_delay: assert property (@(posedge clk) disable iff (!nrst)
    $rose(sup_backup) |-> $past(u_sup.cnt_q) >= $past(u_sup.lim))
    else $error("backup before operate delay");

  a_sup_or_sources: assert property (@(posedge clk) disable iff (!nrst)
    (int'(sup_out_sel) < N_TRIP) && |(sup_src & sup_route[sup_out_sel*N_SRC +: N_SRC])
    |-> sup_drive)
    else $error("routed source not supervised");

  a_unit_off_quiet: assert property (@(posedge clk) disable iff (!nrst)
    !first_unit_enable |=> !retrip_start && !retrip_trip)
    else $error("disabled unit drives output");

  a_block_quiet: assert property (@(posedge clk) disable iff (!nrst)
    unit_block[0] |=> !retrip_start && !retrip_trip)
    else $error("blocked unit drives output");

  a_block_freeze: assert property (@(posedge clk) disable iff (!nrst)
    $past(unit_block[0]) && $past(first_unit_enable)
    |-> u_unit0.cnt_q == $past(u_unit0.cnt_q))
    else $error("timer moved while blocked");

  a_trip_needs_start: assert property (@(posedge clk) disable iff (!nrst)
    retrip_trip |-> retrip_start)
    else $error("trip without start");

  a_timer_clear: assert property (@(posedge clk) disable iff (!nrst)
    $past(first_unit_enable) && !$past(unit_block[0]) && !$past(u_unit0.act)
    |-> u_unit0.cnt_q == '0 && !retrip_start)
    else $error("timer not cleared");

  a_event_start_on: assert property (@(posedge clk) disable iff (!nrst)
    $rose(retrip_start) && $past(unit_ev_en[0]) |-> unit_event[0])
    else $error("start-on event missed");

  a_event_gated: assert property (@(posedge clk) disable iff (!nrst)
    !$past(unit_ev_en[7]) |-> !unit_event[7])
    else $error("disabled event recorded");

  a_stage_gate: assert property (@(posedge clk) disable iff (!nrst)
    ((stage_start & stage_enable) == '0) && (mon_sig == '0) && (u_unit0.cond_q == '0) |=> !retrip_start)
    else $error("unit active without started stage");

  a_sup_restart: assert property (@(posedge clk) disable iff (!nrst)
    !sup_drive |=> u_sup.cnt_q == '0)
    else $error("supervision timer not restarted");

  a_sup_delay_range: assert property (@(posedge clk) disable iff (!nrst)
    u_sup.lim >= bf_pkg::sup_cnt_t'(bf_pkg::SUP_STEP_MS)
    && u_sup.lim <= bf_pkg::sup_cnt_t'(bf_pkg::SUP_SET_MAX * bf_pkg::SUP_STEP_MS))
    else $error("operate delay outside range");

  a_up_trip_start: assert property (@(posedge clk) disable iff (!nrst)
    upstream_trip |-> upstream_start)
    else $error("upstream trip without start");

  a_start_prompt: assert property (@(posedge clk) disable iff (!nrst)
    first_unit_enable && !unit_block[0] && unit_mon_en[0] && u_unit0.st[0] && !u_unit0.rst[0] |=> retrip_start)
    else $error("start not raised on stage trip");

  a_cb_reset: assert property (@(posedge clk) disable iff (!nrst)
    cb_open0 && unit_rst_cb_en[0] |=> !u_unit0.cond_q[0])
    else $error("condition kept over breaker open");

  a_stage_drop_reset: assert property (@(posedge clk) disable iff (!nrst)
    unit_rst_stg_en[0] && !u_unit0.st[0] |=> !u_unit0.cond_q[0])
    else $error("condition kept after stage drop");

  a_zero_ph_reset: assert property (@(posedge clk) disable iff (!nrst)
    unit_rst_zc_ph[0] && ph_zero_q |=> !u_unit0.cond_q[0])
    else $error("condition kept at zero current");

  a_cond4_follow: assert property (@(posedge clk) disable iff (!nrst)
    !u_unit1.st[3] |=> !u_unit1.cond_q[3])
    else $error("condition four outlived its signals");

  a_zc_threshold: assert property (@(posedge clk) disable iff (!nrst)
    ph_i_b >= ph_zc_thr |=> !ph_zero_q)
    else $error("zero current above threshold");

  a_event_trip_off: assert property (@(posedge clk) disable iff (!nrst)
    $fell(retrip_trip) && $past(unit_ev_en[3]) |-> unit_event[3])
    else $error("trip-off event missed");

  a_unit_off_timer: assert property (@(posedge clk) disable iff (!nrst)
    !first_unit_enable |=> u_unit0.cnt_q == '0)
    else $error("disabled unit timer running");

  a_mon_disable: assert property (@(posedge clk) disable iff (!nrst)
    !unit_mon_en[0] && !u_unit0.cond_q[0] |=> !u_unit0.cond_q[0])
    else $error("unmonitored condition latched");
endmodule
`default_nettype wire

// ### bf_pkg.sv
package bf_pkg;
  // timer resolution is one millisecond tick
  localparam int CLK_KHZ = 125000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = CLK_KHZ * TICK_US / 1000;
  localparam int SUP_STEP_MS = 100;
  localparam logic [6:0] SUP_SET_MIN = 7'h01;
  localparam logic [6:0] SUP_SET_MAX = 7'h64;
  localparam int SUP_CNT_W = 14;
  localparam int UNIT_CNT_W = 16;
  localparam int N_TRIP_MAX = 4;
  localparam int N_COND = 4;
  localparam int N_SLOT = 6;
  localparam int N_SLOT4 = 3;
  localparam int EV_START_ON = 0;
  localparam int EV_START_OFF = 1;
  localparam int EV_TRIP_ON = 2;
  localparam int EV_TRIP_OFF = 3;
  typedef logic [SUP_CNT_W-1:0] sup_cnt_t;
  typedef logic [UNIT_CNT_W-1:0] unit_cnt_t;
endpackage

// ### bf_sup.sv
`timescale 1ns/10ps
`default_nettype none
module bf_sup (
  input wire logic clk,
  input wire logic nrst,
  input wire logic tick,
  input wire logic drive,
  input wire logic [6:0] delay_set,
  output logic backup_q
);
  bf_pkg::sup_cnt_t cnt_q;
  bf_pkg::sup_cnt_t lim;

  // out-of-range settings are pulled to the nearest legal step
  function automatic logic [6:0] clamp_set(input logic [6:0] s);
    if (s < bf_pkg::SUP_SET_MIN) return bf_pkg::SUP_SET_MIN;
    if (s > bf_pkg::SUP_SET_MAX) return bf_pkg::SUP_SET_MAX;
    return s;
  endfunction

  assign lim = bf_pkg::sup_cnt_t'(clamp_set(delay_set) * bf_pkg::SUP_STEP_MS);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else if (!drive) begin
      cnt_q <= '0;
    end else if (tick && cnt_q < lim) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      backup_q <= 1'b0;
    end else begin
      backup_q <= drive && (cnt_q >= lim);
    end
  end
endmodule
`default_nettype wire

// ### bf_unit.sv
`timescale 1ns/10ps
`default_nettype none
module bf_unit #(
  parameter int N_STG = 32,
  parameter int N_MON = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic tick,
  input wire logic enable,
  input wire logic block,
  input wire logic [N_STG-1:0] stg_act,
  input wire logic [N_MON-1:0] mon_sig,
  input wire logic cb_open,
  input wire logic ph_zero,
  input wire logic ef_zero,
  input wire logic [3:0] mon_en,
  input wire logic [3*6*$clog2(N_STG)-1:0] slot_idx,
  input wire logic [17:0] slot_vld,
  input wire logic [3*$clog2(N_MON)-1:0] slot4_idx,
  input wire logic [2:0] slot4_vld,
  input wire logic [3:0] rst_cb_en,
  input wire logic [2:0] rst_stg_en,
  input wire logic rst_zc_ph,
  input wire logic rst_zc_ef,
  input wire logic [15:0] delay,
  input wire logic [3:0] ev_en,
  output logic start_q,
  output logic trip_q,
  output logic [3:0] ev_q
);
  localparam int SW = $clog2(N_STG);
  localparam int MW = $clog2(N_MON);
  localparam int SL = bf_pkg::N_SLOT;
  logic [3:0] st, rst, cond_q, cond_d;
  logic act, start_d, trip_d;
  bf_pkg::unit_cnt_t cnt_q;

  function automatic logic any_stg(input logic [N_STG-1:0] v,
      input logic [SL*SW-1:0] idx, input logic [SL-1:0] vld);
    logic r;
    r = 1'b0;
    for (int k = 0; k < SL; k++) begin
      r = r | (vld[k] & v[idx[k*SW +: SW]]);
    end
    return r;
  endfunction

  always_comb begin
    st = '0;
    rst = '0;
    for (int c = 0; c < 3; c++) begin
      st[c] = any_stg(stg_act, slot_idx[c*SL*SW +: SL*SW], slot_vld[c*SL +: SL]);
      rst[c] = (rst_cb_en[c] & cb_open) | (rst_stg_en[c] & ~st[c]);
    end
    for (int k = 0; k < bf_pkg::N_SLOT4; k++) begin
      st[3] = st[3] | (slot4_vld[k] & mon_sig[slot4_idx[k*MW +: MW]]);
    end
    rst[0] = rst[0] | (rst_zc_ph & ph_zero);
    rst[1] = rst[1] | (rst_zc_ef & ef_zero);
    rst[3] = (rst_cb_en[3] & cb_open) | ~st[3];
  end

  // conditions one to three latch so a stage that drops early still waits for cb or current
  assign cond_d = (cond_q | (st & mon_en)) & ~rst & {4{enable}};
  assign act = |cond_d;
  assign start_d = enable & act & ~block;
  assign trip_d = start_d && (cnt_q >= delay);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cond_q <= '0;
    end else begin
      cond_q <= cond_d;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= '0;
    end else if (!enable || (!act && !block)) begin
      cnt_q <= '0;
    end else if (!block && tick && cnt_q != '1) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      start_q <= 1'b0;
      trip_q <= 1'b0;
      ev_q <= '0;
    end else begin
      start_q <= start_d;
      trip_q <= trip_d;
      ev_q[bf_pkg::EV_START_ON] <= ev_en[bf_pkg::EV_START_ON] & start_d & ~start_q;
      ev_q[bf_pkg::EV_START_OFF] <= ev_en[bf_pkg::EV_START_OFF] & ~start_d & start_q;
      ev_q[bf_pkg::EV_TRIP_ON] <= ev_en[bf_pkg::EV_TRIP_ON] & trip_d & ~trip_q;
      ev_q[bf_pkg::EV_TRIP_OFF] <= ev_en[bf_pkg::EV_TRIP_OFF] & ~trip_d & trip_q;
    end
  end
endmodule
`default_nettype wire

// ### bf_field_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// far side: stages, breaker status, contacts, currents
// ----------------------------------------
module bf_field_model #(
  parameter int STG = 5,
  parameter int CB = 2
) (
  input wire logic clk,
  input wire logic fault,
  input wire logic stg_on,
  input wire logic cb_open,
  input wire logic cur_zero,
  input wire logic [7:0] contacts,
  input wire logic [7:0] dins,
  output logic [31:0] stage_start,
  output logic [31:0] stage_enable,
  output logic [7:0] cb_status_pin,
  output logic [7:0] contact_state,
  output logic [7:0] din_pin,
  output logic [15:0] ph_i,
  output logic [15:0] ef_i
);
  logic [31:0] noise_q = 32'h5a5a3c3c;
  // unwatched stages keep toggling but stay disabled, so a bare start must not count
  always_ff @(posedge clk) begin
    noise_q <= ~noise_q;
  end
  always_comb begin
    stage_start = noise_q;
    stage_enable = 32'h0;
    stage_start[STG] = fault;
    stage_enable[STG] = stg_on;
    cb_status_pin = 8'h00;
    cb_status_pin[CB] = cb_open;
  end
  assign contact_state = contacts;
  assign din_pin = dins;
  // a cleared breaker leaves only a small residual current
  assign ph_i = cur_zero ? 16'h0003 : 16'h0400;
  assign ef_i = cur_zero ? 16'h0002 : 16'h0300;
endmodule
`default_nettype wire

// ### breaker_failure_supervisor_tb.sv
`timescale 1ns/10ps
`default_nettype none
module breaker_failure_supervisor_tb;
  // short tick keeps millisecond timers cheap
  localparam int TK = 4;
  logic clk, nrst, sup_backup, rs, rt, us, ut;
  logic fault, stg_on, cb_open, cur_zero;
  logic [15:0] sup_src, ph_i, ef_i;
  logic [63:0] sup_route;
  logic [1:0] sup_out_sel, u_en, unit_block, zc_ph, zc_ef;
  logic [6:0] sup_delay;
  logic [31:0] stage_start, stage_enable, unit_delay;
  logic [7:0] din_pin, contact_state, cb_status_pin, contacts, dins;
  logic [7:0] unit_mon_en, unit_rst_cb_en, unit_ev_en, unit_event, ev_seen;
  logic [179:0] unit_slot_idx;
  logic [35:0] unit_slot_vld;
  logic [23:0] unit_slot4_idx;
  logic [5:0] unit_slot4_vld, unit_cb_sel, unit_rst_stg_en;
  int n_mismatch = 0;
  int n_tests = 0;

  breaker_failure_supervisor #(.TICK_CYCLES(TK)) DUT (.clk(clk), .nrst(nrst), .sup_src(sup_src),
    .sup_route(sup_route), .sup_out_sel(sup_out_sel), .sup_delay(sup_delay), .sup_backup(sup_backup),
    .stage_start(stage_start), .stage_enable(stage_enable), .din_pin(din_pin),
    .contact_state(contact_state), .cb_status_pin(cb_status_pin), .ph_i_a(ph_i), .ph_i_b(ph_i),
    .ph_i_c(ph_i), .ef_i(ef_i), .ph_zc_thr(16'h0010), .ef_zc_thr(16'h0010),
    .first_unit_enable(u_en[0]), .second_unit_enable(u_en[1]), .unit_block(unit_block),
    .unit_mon_en(unit_mon_en), .unit_slot_idx(unit_slot_idx), .unit_slot_vld(unit_slot_vld),
    .unit_slot4_idx(unit_slot4_idx), .unit_slot4_vld(unit_slot4_vld), .unit_cb_sel(unit_cb_sel),
    .unit_rst_cb_en(unit_rst_cb_en), .unit_rst_stg_en(unit_rst_stg_en), .unit_rst_zc_ph(zc_ph),
    .unit_rst_zc_ef(zc_ef), .unit_delay(unit_delay), .unit_ev_en(unit_ev_en), .retrip_start(rs),
    .retrip_trip(rt), .upstream_start(us), .upstream_trip(ut), .unit_event(unit_event));

  bf_field_model PM (.clk(clk), .fault(fault), .stg_on(stg_on), .cb_open(cb_open), .cur_zero(cur_zero),
    .contacts(contacts), .dins(dins), .stage_start(stage_start), .stage_enable(stage_enable),
    .cb_status_pin(cb_status_pin), .contact_state(contact_state), .din_pin(din_pin), .ph_i(ph_i),
    .ef_i(ef_i));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // event pulses last one cycle, so they are gathered here
  always @(posedge clk) begin
    ev_seen <= ev_seen | unit_event;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic sup_run(input int src, input logic [1:0] sel, input logic on);
    sup_out_sel = sel;
    step(2);
    sup_src[src] = 1'b1;
    step(95 * TK);
    chk_bit("backup early", 1'b0, sup_backup);
    step(8 * TK);
    chk_bit("backup late", on, sup_backup);
    step(20 * TK);
    chk_bit("backup held", on, sup_backup);
    sup_src[src] = 1'b0;
    step(2);
    chk_bit("backup release", 1'b0, sup_backup);
  endtask
  task automatic unit_cycle;
    ev_seen = 8'h00;
    fault = 1'b1;
    step(2);
    chk_bit("start", 1'b1, rs);
    step(8 * TK);
    chk_bit("trip early", 1'b0, rt);
    step(4 * TK);
    chk_bit("trip", 1'b1, rt);
    fault = 1'b0;
    step(4);
    chk_bit("latched", 1'b1, rs);
    cb_open = 1'b1;
    step(6);
    chk_byte("cb reset", 8'h00, {6'h0, rs, rt});
    chk_byte("events", 8'h0f, ev_seen);
    cb_open = 1'b0;
    step(2);
  endtask
  task automatic t_drop_zero;
    unit_rst_stg_en[0] = 1'b1;
    fault = 1'b1;
    step(3);
    fault = 1'b0;
    step(3);
    chk_bit("stage drop", 1'b0, rs);
    unit_rst_stg_en[0] = 1'b0;
    zc_ph[0] = 1'b1;
    fault = 1'b1;
    step(3);
    fault = 1'b0;
    cur_zero = 1'b1;
    step(4);
    chk_bit("zero current", 1'b0, rs);
    cur_zero = 1'b0;
    zc_ph[0] = 1'b0;
    step(2);
  endtask
  task automatic t_block;
    fault = 1'b1;
    step(5 * TK);
    unit_block[0] = 1'b1;
    step(2);
    chk_byte("blocked", 8'h00, {6'h0, rs, rt});
    step(20 * TK);
    chk_byte("still blocked", 8'h00, {6'h0, rs, rt});
    unit_block[0] = 1'b0;
    step(3 * TK);
    chk_bit("resumed early", 1'b0, rt);
    step(4 * TK);
    chk_bit("resumed trip", 1'b1, rt);
    fault = 1'b0;
    cb_open = 1'b1;
    step(6);
    cb_open = 1'b0;
  endtask
  task automatic t_gate;
    for (int k = 0; k < 3; k++) begin
      u_en[0] = (k != 0);
      stg_on = (k != 1);
      unit_mon_en[0] = (k != 2);
      fault = 1'b1;
      step(4 * TK);
      if (k == 0) chk_bit("disabled", 1'b0, rs);
      if (k == 1) chk_bit("stage off", 1'b0, rs);
      if (k == 2) chk_bit("unmonitored", 1'b0, rs);
      fault = 1'b0;
      step(2);
    end
    u_en[0] = 1'b1;
    stg_on = 1'b1;
    unit_mon_en[0] = 1'b1;
  endtask
  task automatic t_cond4;
    ev_seen = 8'h00;
    contacts[2] = 1'b1;
    step(2);
    chk_bit("contact start", 1'b1, us);
    step(8 * TK);
    chk_bit("contact trip", 1'b1, ut);
    contacts[2] = 1'b0;
    step(2);
    chk_byte("contact release", 8'h00, {6'h0, us, ut});
    chk_byte("masked events", 8'h50, ev_seen);
    dins[3] = 1'b1;
    step(4);
    chk_bit("input start", 1'b1, us);
    dins[3] = 1'b0;
    step(4);
    chk_bit("input release", 1'b0, us);
  endtask

  initial begin
    nrst = 1'b0;
    sup_src = 16'h0000;
    sup_route = 64'h0000000010000208;
    sup_out_sel = 2'h0;
    sup_delay = 7'h01;
    fault = 1'b0;
    stg_on = 1'b1;
    cb_open = 1'b0;
    cur_zero = 1'b0;
    contacts = 8'h00;
    dins = 8'h00;
    u_en = 2'h3;
    unit_block = 2'h0;
    unit_mon_en = 8'hff;
    unit_slot_idx = 180'h05;
    unit_slot_vld = 36'h000000001;
    unit_slot4_idx = 24'h03a000;
    unit_slot4_vld = 6'h18;
    unit_cb_sel = 6'h12;
    unit_rst_cb_en = 8'h01;
    unit_rst_stg_en = 6'h00;
    zc_ph = 2'h0;
    zc_ef = 2'h0;
    unit_delay = 32'h0005000a;
    unit_ev_en = 8'h5f;
    ev_seen = 8'h00;
    step(16);
    nrst = 1'b1;
    step(4);
    sup_run(3, 2'h0, 1'b1);
    sup_run(9, 2'h0, 1'b1);
    sup_run(3, 2'h1, 1'b0);
    unit_cycle();
    t_drop_zero();
    t_block();
    t_gate();
    t_cond4();
    report_and_stop();
  end
  // the tests need about 1800 cycles; over twenty-five times that means a hang
  initial begin
    #400000;
    n_mismatch++;
    report_and_stop();
  end
endmodule
`default_nettype wire
